// [rtl/uart_tx_core.sv]
`timescale 1ns/1ps
`include "uart_tx_params.svh"

module tx_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64
) (
  input  wire logic                       clk_in,
  input  wire logic                       rst_b_in,
  input  wire logic                       fill_valid_in,
  input  wire logic [WIDTH-1:0]           fill_data_in,
  output logic                            fill_ready_out,
  output logic                            drain_valid_out,
  output logic [WIDTH-1:0]                drain_data_out,
  input  wire logic                       drain_ready_in,
  output logic [$clog2(DEPTH+1)-1:0]      level_out
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [CW-1:0]    next_count;
  logic             push;
  logic             pop;

  always_comb
  begin
    fill_ready_out  = (count != CW'(DEPTH));
    drain_valid_out = (count != '0);
    drain_data_out  = mem[rd_ptr];
    level_out       = count;
    push            = fill_valid_in && fill_ready_out;
    pop             = drain_ready_in && drain_valid_out;
    next_wr_ptr     = push ? ((wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr     = pop ? ((rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
    next_count      = count + CW'(push) - CW'(pop);
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // The array has no reset so that it can map onto plain memory.
  always_ff @(posedge clk_in)
  begin
    if (push)
      mem[wr_ptr] <= fill_data_in;
  end

  write_advance_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    push && !pop |=> count == $past(count) + 1'b1)
    else $error("accepted write did not advance fifo level");
endmodule

module uart_tx_core #(
  parameter int FIFO_DEPTH = 64
) (
  input  wire logic                   clk_in,
  input  wire logic                   rst_b_in,
  input  wire logic                   cfg_load_in,
  input  wire uart_tx_pkg::divisor_t  divisor_in,
  input  wire logic                   prescale_sel_in,
  input  wire uart_tx_pkg::frame_cfg_t frame_cfg_in,
  input  wire logic                   fifo_enable_in,
  input  wire logic                   wr_en_in,
  input  wire logic [7:0]             wr_data_in,
  output logic                        wr_ready_out,
  output logic                        tx_out,
  output logic [7:0]                  line_status_out
);
  localparam int LW = $clog2(FIFO_DEPTH+1);

  uart_tx_pkg::divisor_t   div;
  uart_tx_pkg::frame_cfg_t frame;
  logic                    prescale_on;
  logic [1:0]              presc_cnt;
  logic [19:0]             acc;
  uart_tx_pkg::divisor_t   next_div;
  uart_tx_pkg::frame_cfg_t next_frame;
  logic                    next_prescale_on;
  logic [1:0]              next_presc_cnt;
  logic [19:0]             next_acc;
  logic                    presc_tick;
  logic                    sample_tick;
  logic [19:0]             div_total;
  logic [19:0]             acc_sum;
  logic [4:0]              bit_len;

  // Generator: fractional divide by accumulating sixteenths per prescaled tick.
  always_comb
  begin
    next_div         = cfg_load_in ? divisor_in : div;
    next_frame       = cfg_load_in ? frame_cfg_in : frame;
    next_prescale_on = cfg_load_in ? prescale_sel_in : prescale_on;
    presc_tick       = !prescale_on || (presc_cnt == `PRESCALE_LAST);
    next_presc_cnt   = prescale_on ? presc_cnt + 1'b1 : 2'h0;
    div_total        = {div.high, div.low, div.fraction[3:0]};
    // A zero integer part would tick on every prescaled tick, so it runs as an integer part of one.
    if ({div.high, div.low} == 16'h0000)
      div_total = {16'h0001, div.fraction[3:0]};
    acc_sum     = acc + `FRACTION_STEP;
    sample_tick = presc_tick && (acc_sum >= div_total);
    next_acc    = acc;
    if (presc_tick)
      next_acc = sample_tick ? acc_sum - div_total : acc_sum;
    if (cfg_load_in)
      next_acc = 20'h0_0000;
    unique case (uart_tx_pkg::sample_mode_t'(div.fraction[5:4]))
      uart_tx_pkg::MODE_8X:   bit_len = `TICKS_8X;
      uart_tx_pkg::MODE_4X:   bit_len = `TICKS_4X;
      uart_tx_pkg::MODE_16X,
      uart_tx_pkg::MODE_RSVD: bit_len = `TICKS_16X;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      div         <= '{`DIV_HIGH_RESET, `DIV_LOW_RESET, `DIV_FRACTION_RESET};
      frame       <= '0;
      prescale_on <= 1'b0;
      presc_cnt   <= 2'h0;
      acc         <= 20'h0_0000;
    end
    else
    begin
      div         <= next_div;
      frame       <= next_frame;
      prescale_on <= next_prescale_on;
      presc_cnt   <= next_presc_cnt;
      acc         <= next_acc;
    end
  end

  logic            fifo_valid;
  logic [7:0]      fifo_data;
  logic [LW-1:0]   fifo_level;
  logic            push;
  logic            pop;
  logic [LW-1:0]   next_level;
  logic            next_wr_ready;

  // Without FIFO enable the buffer behaves as a single holding byte.
  always_comb
  begin
    push          = wr_en_in && wr_ready_out;
    next_level    = fifo_level + LW'(push) - LW'(pop);
    next_wr_ready = fifo_enable_in ? (next_level != LW'(FIFO_DEPTH)) : (next_level == '0);
  end

  tx_byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in          (clk_in),
    .rst_b_in        (rst_b_in),
    .fill_valid_in   (push),
    .fill_data_in    (wr_data_in),
    .fill_ready_out  (),
    .drain_valid_out (fifo_valid),
    .drain_data_out  (fifo_data),
    .drain_ready_in  (pop),
    .level_out       (fifo_level)
  );

  uart_tx_pkg::tx_state_t state;
  uart_tx_pkg::tx_state_t next_state;
  logic [3:0]             tick_cnt;
  logic [2:0]             bit_idx;
  logic [7:0]             shreg;
  logic                   par;
  logic [3:0]             next_tick_cnt;
  logic [2:0]             next_bit_idx;
  logic [7:0]             next_shreg;
  logic                   next_par;
  logic                   next_tx;
  logic [7:0]             next_status;
  logic                   bit_end;
  logic [7:0]             data_mask;

  always_comb
  begin
    next_state    = state;
    next_bit_idx  = bit_idx;
    next_shreg    = shreg;
    next_par      = par;
    pop           = 1'b0;
    bit_end       = sample_tick && (tick_cnt == 4'(bit_len - 5'h01));
    data_mask     = 8'hFF >> (2'h3 - frame.data_bits);
    next_tick_cnt = sample_tick ? (bit_end ? 4'h0 : tick_cnt + 1'b1) : tick_cnt;
    unique case (state)
      // A frame starts on a sample tick so that the start bit lasts a full bit time.
      uart_tx_pkg::ST_IDLE:
        if (fifo_valid && sample_tick)
        begin
          pop           = 1'b1;
          next_shreg    = fifo_data;
          next_par      = ^(fifo_data & data_mask) ^ !frame.parity_even;
          next_state    = uart_tx_pkg::ST_START;
          next_tick_cnt = 4'h0;
        end
      uart_tx_pkg::ST_START:
        if (bit_end)
        begin
          next_state   = uart_tx_pkg::ST_DATA;
          next_bit_idx = 3'h0;
        end
      uart_tx_pkg::ST_DATA:
        if (bit_end)
        begin
          next_shreg   = shreg >> 1;
          next_bit_idx = bit_idx + 1'b1;
          if (bit_idx == `FIRST_LAST_BIT + {1'b0, frame.data_bits})
          begin
            next_state   = frame.parity_en ? uart_tx_pkg::ST_PARITY : uart_tx_pkg::ST_STOP;
            next_bit_idx = 3'h0;
          end
        end
      uart_tx_pkg::ST_PARITY:
        if (bit_end)
          next_state = uart_tx_pkg::ST_STOP;
      uart_tx_pkg::ST_STOP:
        if (bit_end)
        begin
          if (frame.two_stop && bit_idx == 3'h0)
            next_bit_idx = 3'h1;
          else
            next_state = uart_tx_pkg::ST_IDLE;
        end
      default:
        next_state = uart_tx_pkg::ST_IDLE;
    endcase
    unique case (next_state)
      uart_tx_pkg::ST_START:  next_tx = 1'b0;
      uart_tx_pkg::ST_DATA:   next_tx = next_shreg[0];
      uart_tx_pkg::ST_PARITY: next_tx = par;
      default:                next_tx = 1'b1;
    endcase
    next_status                      = 8'h00;
    next_status[`STATUS_FIFO_EMPTY]  = (next_level == '0);
    next_status[`STATUS_SHIFT_EMPTY] = (next_level == '0) && (next_state == uart_tx_pkg::ST_IDLE);
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state           <= uart_tx_pkg::ST_IDLE;
      tick_cnt        <= 4'h0;
      bit_idx         <= 3'h0;
      shreg           <= 8'h00;
      par             <= 1'b0;
      tx_out          <= 1'b1;
      wr_ready_out    <= 1'b1;
      line_status_out <= `LINE_STATUS_RESET;
    end
    else
    begin
      state           <= next_state;
      tick_cnt        <= next_tick_cnt;
      bit_idx         <= next_bit_idx;
      shreg           <= next_shreg;
      par             <= next_par;
      tx_out          <= next_tx;
      wr_ready_out    <= next_wr_ready;
      line_status_out <= next_status;
    end
  end

  logic [7:0] byte_taken;
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      byte_taken <= 8'h00;
    else if (pop)
      byte_taken <= fifo_data;
  end

  idle_line_high_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    state == uart_tx_pkg::ST_IDLE |-> tx_out)
    else $error("line not idle high");
  start_bit_low_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $rose(state == uart_tx_pkg::ST_START) |-> !tx_out ##1 !tx_out)
    else $error("start bit not low");
  lsb_first_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $rose(state == uart_tx_pkg::ST_DATA) |-> tx_out == byte_taken[0])
    else $error("first data bit is not bit zero");
  load_after_stop_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    state == uart_tx_pkg::ST_STOP && !(bit_end && (!frame.two_stop || bit_idx == 3'h1))
    |=> state == uart_tx_pkg::ST_STOP && !pop)
    else $error("byte loaded mid frame");
  bit_length_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    state != uart_tx_pkg::ST_IDLE && !bit_end
    |=> $stable(state) && $stable(tx_out) && tick_cnt == $past(tick_cnt) + 4'($past(sample_tick)))
    else $error("bit time wrong length");
  fifo_empty_flag_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    line_status_out[`STATUS_FIFO_EMPTY] == (fifo_level == '0))
    else $error("fifo empty flag disagrees with level");
  shift_empty_flag_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    line_status_out[`STATUS_SHIFT_EMPTY] |-> state == uart_tx_pkg::ST_IDLE && !fifo_valid)
    else $error("shift empty flag set while busy");
  prescale_gap_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    prescale_on && presc_tick |=> (!presc_tick || !prescale_on) [*3])
    else $error("prescaler not dividing by four");
  acc_range_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    acc < div_total || $past(cfg_load_in))
    else $error("fraction accumulator out of range");

  frame_done_c: cover property (@(posedge clk_in) disable iff (!rst_b_in)
    state == uart_tx_pkg::ST_STOP ##1 state == uart_tx_pkg::ST_IDLE);
  parity_sent_c: cover property (@(posedge clk_in) disable iff (!rst_b_in)
    state == uart_tx_pkg::ST_PARITY);
  fifo_full_c: cover property (@(posedge clk_in) disable iff (!rst_b_in)
    fifo_level == LW'(FIFO_DEPTH));
  mode_4x_c: cover property (@(posedge clk_in) disable iff (!rst_b_in)
    bit_end && bit_len == `TICKS_4X);
endmodule

// [rtl/uart_tx_params.svh]
`ifndef UART_TX_PARAMS_SVH
`define UART_TX_PARAMS_SVH

`define DIV_LOW_RESET      8'h01
`define DIV_HIGH_RESET     8'h00
`define DIV_FRACTION_RESET 8'h00
`define STATUS_FIFO_EMPTY  5
`define STATUS_SHIFT_EMPTY 6
`define LINE_STATUS_RESET  8'h60
`define FRACTION_STEP      20'h0_0010
`define PRESCALE_LAST      2'h3
`define TICKS_16X          5'h10
`define TICKS_8X           5'h08
`define TICKS_4X           5'h04
`define FIRST_LAST_BIT     3'h4

`endif

// [rtl/uart_tx_pkg.sv]
package uart_tx_pkg;

  typedef enum logic [1:0] {
    MODE_16X  = 2'b00,
    MODE_8X   = 2'b01,
    MODE_4X   = 2'b10,
    MODE_RSVD = 2'b11
  } sample_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_START  = 3'b001,
    ST_DATA   = 3'b010,
    ST_PARITY = 3'b011,
    ST_STOP   = 3'b100
  } tx_state_t;

  typedef struct packed {
    logic [1:0] data_bits;
    logic       parity_en;
    logic       parity_even;
    logic       two_stop;
  } frame_cfg_t;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
    logic [7:0] fraction;
  } divisor_t;

endpackage

// [tb/testbench.sv]
`timescale 1ns/1ps

module testbench;
  logic                    clk_in;
  logic                    rst_b_in;
  logic                    cfg_load_in;
  uart_tx_pkg::divisor_t   divisor_in;
  logic                    prescale_sel_in;
  uart_tx_pkg::frame_cfg_t frame_cfg_in;
  logic                    fifo_enable_in;
  logic                    wr_en_in;
  logic [7:0]              wr_data_in;
  logic                    wr_ready_out;
  logic                    tx_out;
  logic [7:0]              line_status_out;
  logic [9:0]              rx_word;
  logic                    rx_valid;
  int                      bit16;
  int                      fail_count;
  int                      num_checks;
  int                      seed;
  int                      acc;
  logic                    ok;
  logic [9:0]              exp_q[$];

  uart_tx_core #(.FIFO_DEPTH(4)) u_uart_tx_core (
    .clk_in          (clk_in),
    .rst_b_in        (rst_b_in),
    .cfg_load_in     (cfg_load_in),
    .divisor_in      (divisor_in),
    .prescale_sel_in (prescale_sel_in),
    .frame_cfg_in    (frame_cfg_in),
    .fifo_enable_in  (fifo_enable_in),
    .wr_en_in        (wr_en_in),
    .wr_data_in      (wr_data_in),
    .wr_ready_out    (wr_ready_out),
    .tx_out          (tx_out),
    .line_status_out (line_status_out)
  );

  uart_rx_model u_uart_rx_model (
    .clk_in    (clk_in),
    .line_in   (tx_out),
    .bit16_in  (bit16),
    .nbits_in  (int'(frame_cfg_in.data_bits) + 5),
    .par_in    (frame_cfg_in.parity_en),
    .two_in    (frame_cfg_in.two_stop),
    .word_out  (rx_word),
    .valid_out (rx_valid)
  );

  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Expected frame word: stop flag, parity bit, data masked to the frame width.
  function automatic logic [9:0] expect_word(input logic [7:0] b);
    logic [7:0] m;
    m = b & (8'hFF >> (3 - frame_cfg_in.data_bits));
    return {1'b1, frame_cfg_in.parity_en & (^m ^ ~frame_cfg_in.parity_even), m};
  endfunction

  // Holds the strobe until accepted or the tries run out; caller lowers it.
  task automatic wr(input logic [7:0] b, input int tries, output logic got);
    got = 1'b0;
    wr_en_in = 1'b1;
    wr_data_in = b;
    for (int t = 0; t < tries && !got; t++)
    begin
      if (wr_ready_out === 1'b1)
      begin
        got = 1'b1;
        exp_q.push_back(expect_word(b));
      end
      @(posedge clk_in);
      @(negedge clk_in);
    end
  endtask

  task automatic send_random(input int n);
    for (int i = 0; i < n; i++)
    begin
      wr(8'($random(seed)), 400, ok);
      check("write accepted", ok, 1);
    end
    wr_en_in = 1'b0;
  endtask

  task automatic wait_idle();
    int t;
    t = 0;
    while (t < 20000 && !(line_status_out === 8'h60 && exp_q.size() == 0))
    begin
      @(negedge clk_in);
      t++;
    end
    if (t >= 20000)
    begin
      check("idle timeout", 0, 1);
      tally_and_finish();
    end
  endtask

  // d16 is the divisor in sixteenths; software splits it into the three bytes.
  task automatic set_cfg(input logic [1:0] mode, input logic ps, input int d16,
                         input logic [4:0] fc);
    divisor_in.high = 8'((d16 >> 4) >> 8);
    divisor_in.low = 8'((d16 >> 4) & 8'hFF);
    divisor_in.fraction = {2'b00, mode, 4'(d16 & 4'hF)};
    prescale_sel_in = ps;
    frame_cfg_in = fc;
    cfg_load_in = 1'b1;
    @(negedge clk_in);
    cfg_load_in = 1'b0;
    // The reserved mode code runs as 16X sampling.
    bit16 = (ps ? 4 : 1) * d16 * ((mode == 2'b11) ? 16 : (16 >> mode));
  endtask

  always @(posedge clk_in)
    if (rx_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("unexpected frame", 1, 0);
      else
        check("frame word", rx_word, exp_q.pop_front());
    end

  initial
  begin
    seed = 86944;
    fail_count = 0;
    num_checks = 0;
    rst_b_in = 1'b0;
    cfg_load_in = 1'b0;
    divisor_in = '0;
    prescale_sel_in = 1'b0;
    frame_cfg_in = '0;
    fifo_enable_in = 1'b1;
    wr_en_in = 1'b0;
    wr_data_in = 8'h00;
    bit16 = 256;
    repeat (2) @(negedge clk_in);
    check("reset line", tx_out, 1);
    check("reset status", line_status_out, 8'h60);
    check("reset ready", wr_ready_out, 1);
    rst_b_in = 1'b1;
    @(negedge clk_in);
    // Default divisor of one, 16X, five data bits.
    send_random(3);
    wait_idle();
    $display("default divisor test done");
    // Modes, prescaler, integer and fractional divisors, parity and stop options.
    set_cfg(2'b01, 1'b1, 32, 5'b11_1_1_1);
    send_random(3);
    wait_idle();
    set_cfg(2'b10, 1'b0, 56, 5'b11_1_0_0);
    send_random(3);
    wait_idle();
    set_cfg(2'b00, 1'b0, 24, 5'b10_0_0_0);
    send_random(3);
    wait_idle();
    set_cfg(2'b01, 1'b0, 17, 5'b01_1_1_0);
    send_random(3);
    wait_idle();
    $display("mode and divisor test done");
    // Fill until refused: one byte in the shifter plus four queued.
    set_cfg(2'b11, 1'b0, 16, 5'b11_0_0_0);
    acc = 0;
    ok = 1'b1;
    while (ok && acc < 10)
    begin
      wr(8'($random(seed)), 3, ok);
      acc += int'(ok);
    end
    wr_en_in = 1'b0;
    check("fifo accepted count", acc, 5);
    check("busy status", line_status_out[6:5], 2'b00);
    wait_idle();
    check("drained status", line_status_out, 8'h60);
    check("drained ready", wr_ready_out, 1);
    $display("fifo fill test done");
    // Without the FIFO only one byte waits behind the shifter.
    fifo_enable_in = 1'b0;
    acc = 0;
    ok = 1'b1;
    while (ok && acc < 10)
    begin
      wr(8'($random(seed)), 3, ok);
      acc += int'(ok);
    end
    wr_en_in = 1'b0;
    check("holding accepted count", acc, 2);
    wait_idle();
    $display("holding register test done");
    tally_and_finish();
  end
endmodule

// [tb/uart_rx_model.sv]
`timescale 1ns/1ps

// Remote receiver: samples each bit at its centre, positions kept in sixteenths of a cycle.
module uart_rx_model (
  input  wire logic       clk_in,
  input  wire logic       line_in,
  input  wire logic [31:0] bit16_in,
  input  wire logic [31:0] nbits_in,
  input  wire logic       par_in,
  input  wire logic       two_in,
  output logic [9:0]      word_out,
  output logic            valid_out
);
  initial
  begin : rx
    int cyc;
    int k;
    int n;
    logic [11:0] s;
    logic [7:0] d;
    logic ok;
    valid_out = 1'b0;
    word_out = '0;
    forever
    begin
      @(posedge clk_in);
      valid_out <= 1'b0;
      if (line_in === 1'b0)
      begin
        n = nbits_in + 2 + int'(par_in) + int'(two_in);
        cyc = 0;
        k = 0;
        s = '0;
        while (k < n)
        begin
          @(posedge clk_in);
          cyc++;
          if (cyc * 32 >= bit16_in * (2 * k + 1))
          begin
            s[k] = line_in;
            k++;
          end
        end
        d = '0;
        for (int i = 0; i < nbits_in; i++)
          d[i] = s[i + 1];
        ok = (s[0] === 1'b0) && (s[n - 1] === 1'b1) && (!two_in || s[n - 2] === 1'b1);
        // Line must stay high until five cycles before the end of the last stop bit.
        while (cyc * 32 < 2 * bit16_in * n - 160)
        begin
          @(posedge clk_in);
          cyc++;
          if (line_in !== 1'b1)
            ok = 1'b0;
        end
        word_out <= {ok, par_in ? s[nbits_in + 1] : 1'b0, d};
        valid_out <= 1'b1;
      end
    end
  end
endmodule
